// ===== rtl/tpwm_pkg.sv
package tpwm_pkg;

	// ****************************************
	// register byte offsets on the apb bus
	// ****************************************
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0c;
	localparam logic [7:0] ADDR_ALTCOUNT = 8'h10;
	localparam logic [7:0] ADDR_CMP1 = 8'h14;
	localparam logic [7:0] ADDR_CMP2 = 8'h18;
	localparam logic [7:0] ADDR_CAP1 = 8'h1c;
	localparam logic [7:0] ADDR_CAP2 = 8'h20;

	// ****************************************
	// field positions
	// ****************************************
	localparam int C1_LVL1 = 0;
	localparam int C1_LVL2 = 1;
	localparam int C1_CAPIE = 7;
	localparam int C2_PSC_LO = 0;
	localparam int C2_OPM = 3;
	localparam int C2_PWM = 4;
	localparam int C2_OUTEN = 7;
	localparam int ST_FREEZE = 2;

	// ****************************************
	// reset values and counts
	// ****************************************
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'hfc;
	localparam logic [7:0] COUNT_RELOAD = 8'hfc;
	localparam logic [7:0] COUNT_TOP = 8'hff;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [12:0] PRESC_DIV2 = 13'h0002;
	localparam logic [12:0] PRESC_DIV4 = 13'h0004;
	localparam logic [12:0] PRESC_DIV8 = 13'h0008;
	localparam logic [12:0] PRESC_DIV8000 = 13'h1f40;
	localparam logic [7:0] PWM_TICK_OFFSET = 8'h05;

	typedef struct packed {
		logic firstMatchLevel;
		logic secondMatchLevel;
		logic captureIrqEnable;
		logic compareOutputEnable;
		logic pwmMode;
		logic singlePulseModeBit;
		logic [1:0] prescaleSelect;
	} tpwm_ctrl_t;

	localparam tpwm_ctrl_t CTRL_RESET = '0;

	typedef struct packed {
		logic compareOutputPin;
		logic compareOutputDriven;
		logic secondCompareOutputPin;
		logic secondCompareOutputDriven;
	} tpwm_pins_t;

endpackage

// ===== rtl/tpwm_timer.sv
`timescale 1ns/100ps
// What this block does
// - in pwm mode both compare writes wait in shadows until the period ends
// - in pwm mode a period compare match reloads the counter with fch
// - first match drives the first level, period match the second level
// - equal match levels hold the pin constant during pwm
// - levels one then zero give a pulse of second compare minus first compare
// - ticks from period start to a compare event equal value plus five
// - prescaler divides the clock by 2, 4, 8 or 8000 by select field
// - pwm mode never sets either compare flag
// - pwm period match sets capture one flag and may request an interrupt
// - pwm mode disconnects first capture pin, second capture still works
// - pwm mode wins over single pulse mode when both are set
// - compare output enable hands the pin to compare one function alone
// - status holds five flags in bits 7 to 3, freeze at bit 2
// - a flag clears after a status read then an access to its register
// - overflow sets on ff to 00 rollover; alternate counter never clears it
// - second capture pin event latches counter and sets capture two flag
// - outside pwm a counter equal to a compare sets its flag
// - freeze stops prescaler and counter and disables both compare pins
module tpwm_timer
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic firstCapturePin,
	input wire logic secondCapturePin,
	output tpwm_pkg::tpwm_pins_t pinOut,
	output logic captureIrq
);
	import tpwm_pkg::*;

	// flag vector order, also the status bit order from bit 7 down
	localparam int F_CAP1 = 4;
	localparam int F_CMP1 = 3;
	localparam int F_OVF = 2;
	localparam int F_CAP2 = 1;
	localparam int F_CMP2 = 0;
	localparam logic [4:0][7:0] TIED_ADDR = {ADDR_CAP1, ADDR_CMP1, ADDR_COUNT, ADDR_CAP2, ADDR_CMP2};

	tpwm_ctrl_t ctrl_reg;
	logic freeze_reg;
	logic [4:0] flag_reg;
	logic [4:0] flag_next;
	logic [4:0] armed_reg;
	logic [4:0] evtSet;
	logic [4:0] evtClr;
	logic [7:0] count_reg;
	logic [12:0] presc_reg;
	logic [12:0] prescLimit;
	logic [7:0] cmp1Buf_reg;
	logic [7:0] cmp2Buf_reg;
	logic [7:0] cmp1_reg;
	logic [7:0] cmp2_reg;
	logic [7:0] cap1_reg;
	logic [7:0] cap2_reg;
	logic [2:0] cap1Sync_reg;
	logic [2:0] cap2Sync_reg;
	logic lvl1_reg;
	logic lvl1_next;
	logic lvl2_reg;
	logic lvl2_next;
	tpwm_pins_t pins_reg;
	logic irq_reg;
	logic [31:0] prdata_reg;
	logic slverr_reg;
	logic [7:0] readMux;
	logic mapped;
	logic setupPh;
	logic accessPh;
	logic wrEn;
	logic rdEn;
	logic statusRead;
	logic countWrite;
	logic pwmOn;
	logic opmOn;
	logic running;
	logic tick;
	logic match1;
	logic match2;
	logic reload;
	logic cap1Edge;
	logic cap2Edge;

	// ****************************************
	// bus decode
	// ****************************************
	assign setupPh = psel & ~penable;
	assign accessPh = psel & penable;
	assign wrEn = accessPh & pwrite & mapped;
	assign rdEn = accessPh & ~pwrite & mapped;
	assign statusRead = rdEn & (paddr == ADDR_STATUS);
	assign countWrite = wrEn & (paddr == ADDR_COUNT);
	assign pready = accessPh;
	assign prdata = prdata_reg;
	assign pslverr = slverr_reg & accessPh;

	always_comb
	begin
		mapped = 1'b1;
		readMux = 8'h00;
		case (paddr)
			ADDR_CTRL1: readMux = {ctrl_reg.captureIrqEnable, 5'h00, ctrl_reg.secondMatchLevel,
				ctrl_reg.firstMatchLevel};
			ADDR_CTRL2: readMux = {ctrl_reg.compareOutputEnable, 2'h0, ctrl_reg.pwmMode,
				ctrl_reg.singlePulseModeBit, 1'b0, ctrl_reg.prescaleSelect};
			ADDR_STATUS: readMux = {flag_reg, freeze_reg, 2'h0};
			ADDR_COUNT: readMux = count_reg;
			ADDR_ALTCOUNT: readMux = count_reg;
			ADDR_CMP1: readMux = cmp1Buf_reg;
			ADDR_CMP2: readMux = cmp2Buf_reg;
			ADDR_CAP1: readMux = cap1_reg;
			ADDR_CAP2: readMux = cap2_reg;
			default: mapped = 1'b0;
		endcase
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			prdata_reg <= 32'h00000000;
			slverr_reg <= 1'b0;
		end
		else if (setupPh)
		begin
			prdata_reg <= {24'h000000, readMux};
			slverr_reg <= ~mapped;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (reset)
			ctrl_reg <= CTRL_RESET;
		else if (wrEn && paddr == ADDR_CTRL1)
		begin
			ctrl_reg.firstMatchLevel <= pwdata[C1_LVL1];
			ctrl_reg.secondMatchLevel <= pwdata[C1_LVL2];
			ctrl_reg.captureIrqEnable <= pwdata[C1_CAPIE];
		end
		else if (wrEn && paddr == ADDR_CTRL2)
		begin
			ctrl_reg.compareOutputEnable <= pwdata[C2_OUTEN];
			ctrl_reg.pwmMode <= pwdata[C2_PWM];
			ctrl_reg.singlePulseModeBit <= pwdata[C2_OPM];
			ctrl_reg.prescaleSelect <= pwdata[C2_PSC_LO +: 2];
		end
	end

	// only the freeze bit is writable; reserved bits are dropped
	always_ff @(posedge mclk)
	begin
		if (reset)
			freeze_reg <= STATUS_RESET[ST_FREEZE];
		else if (wrEn && paddr == ADDR_STATUS)
			freeze_reg <= pwdata[ST_FREEZE];
	end

	assign pwmOn = ctrl_reg.pwmMode;
	assign opmOn = ctrl_reg.singlePulseModeBit & ~pwmOn;
	assign running = ~freeze_reg;

	// ****************************************
	// prescaler and counter
	// ****************************************
	always_comb
	begin
		case (ctrl_reg.prescaleSelect)
			2'h0: prescLimit = PRESC_DIV2 - 13'h0001;
			2'h1: prescLimit = PRESC_DIV4 - 13'h0001;
			2'h2: prescLimit = PRESC_DIV8 - 13'h0001;
			default: prescLimit = PRESC_DIV8000 - 13'h0001;
		endcase
	end

	// >= keeps the divider safe when the select drops to a shorter factor
	assign tick = running & (presc_reg >= prescLimit);

	always_ff @(posedge mclk)
	begin
		if (reset)
			presc_reg <= 13'h0000;
		else if (running)
			presc_reg <= tick ? 13'h0000 : presc_reg + 13'h0001;
	end

	assign match1 = tick & (count_reg == cmp1_reg);
	assign match2 = tick & (count_reg == cmp2_reg);
	assign reload = match2 & (pwmOn | opmOn);

	always_ff @(posedge mclk)
	begin
		if (reset)
			count_reg <= COUNT_RESET;
		else if (countWrite)
			count_reg <= COUNT_RESET;
		else if (reload)
			count_reg <= COUNT_RELOAD;
		else if (tick)
			count_reg <= count_reg + 8'h01;
	end

	// ****************************************
	// compare values with shadow buffers
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cmp1Buf_reg <= CMP_RESET;
			cmp2Buf_reg <= CMP_RESET;
		end
		else
		begin
			if (wrEn && paddr == ADDR_CMP1)
				cmp1Buf_reg <= pwdata[7:0];
			if (wrEn && paddr == ADDR_CMP2)
				cmp2Buf_reg <= pwdata[7:0];
		end
	end

	// in pwm the active pair only moves at the period end, so no spikes
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cmp1_reg <= CMP_RESET;
			cmp2_reg <= CMP_RESET;
		end
		else if (!pwmOn || match2)
		begin
			cmp1_reg <= cmp1Buf_reg;
			cmp2_reg <= cmp2Buf_reg;
		end
	end

	// ****************************************
	// capture inputs
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cap1Sync_reg <= 3'h0;
			cap2Sync_reg <= 3'h0;
		end
		else
		begin
			cap1Sync_reg <= {cap1Sync_reg[1:0], firstCapturePin};
			cap2Sync_reg <= {cap2Sync_reg[1:0], secondCapturePin};
		end
	end

	// rising edge captures; the first pin is cut off in pwm
	assign cap1Edge = ~pwmOn & cap1Sync_reg[1] & ~cap1Sync_reg[2];
	assign cap2Edge = cap2Sync_reg[1] & ~cap2Sync_reg[2];

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cap1_reg <= 8'h00;
			cap2_reg <= 8'h00;
		end
		else
		begin
			if (cap1Edge)
				cap1_reg <= count_reg;
			if (cap2Edge)
				cap2_reg <= count_reg;
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	assign evtSet[F_CAP1] = cap1Edge | (pwmOn & match2);
	assign evtSet[F_CMP1] = ~pwmOn & match1;
	assign evtSet[F_OVF] = tick & ~reload & (count_reg == COUNT_TOP);
	assign evtSet[F_CAP2] = cap2Edge;
	assign evtSet[F_CMP2] = ~pwmOn & match2;

	// a new event in the clearing cycle wins over the clear
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : flagGen
			assign evtClr[gi] = armed_reg[gi] & accessPh & (paddr == TIED_ADDR[gi]);
			assign flag_next[gi] = evtSet[gi] | (flag_reg[gi] & ~evtClr[gi]);
		end
	endgenerate

	always_ff @(posedge mclk)
	begin
		if (reset)
			flag_reg <= STATUS_RESET[7:3];
		else
			flag_reg <= flag_next;
	end

	// a status read arms only the flags that were up when it was read
	always_ff @(posedge mclk)
	begin
		if (reset)
			armed_reg <= 5'h00;
		else if (statusRead)
			armed_reg <= prdata_reg[7:3];
		else
			armed_reg <= armed_reg & ~evtClr;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			irq_reg <= 1'b0;
		else
			irq_reg <= flag_next[F_CAP1] & ctrl_reg.captureIrqEnable;
	end

	assign captureIrq = irq_reg;

	// ****************************************
	// compare output pins
	// ****************************************
	always_comb
	begin
		lvl1_next = lvl1_reg;
		lvl2_next = lvl2_reg;
		if (pwmOn)
		begin
			if (ctrl_reg.firstMatchLevel == ctrl_reg.secondMatchLevel)
				lvl1_next = ctrl_reg.firstMatchLevel;
			else if (match2)
				lvl1_next = ctrl_reg.secondMatchLevel;
			else if (match1)
				lvl1_next = ctrl_reg.firstMatchLevel;
		end
		else
		begin
			if (match1)
				lvl1_next = ctrl_reg.firstMatchLevel;
			if (match2)
				lvl2_next = ctrl_reg.secondMatchLevel;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			lvl1_reg <= 1'b0;
			lvl2_reg <= 1'b0;
		end
		else
		begin
			lvl1_reg <= lvl1_next;
			lvl2_reg <= lvl2_next;
		end
	end

	// frozen pins go undriven and low to save power
	always_ff @(posedge mclk)
	begin
		if (reset)
			pins_reg <= '0;
		else
		begin
			pins_reg.compareOutputDriven <= ctrl_reg.compareOutputEnable & running;
			pins_reg.compareOutputPin <= ctrl_reg.compareOutputEnable & running & lvl1_next;
			pins_reg.secondCompareOutputDriven <= ~pwmOn & running;
			pins_reg.secondCompareOutputPin <= ~pwmOn & running & lvl2_next;
		end
	end

	assign pinOut = pins_reg;

	// ****************************************
	// checks
	// ****************************************
	logic [7:0] ticksSince_reg;
	logic periodValid_reg;

	always_ff @(posedge mclk)
	begin
		if (reset || countWrite || !pwmOn)
		begin
			ticksSince_reg <= 8'h00;
			periodValid_reg <= 1'b0;
		end
		else if (reload)
		begin
			ticksSince_reg <= 8'h00;
			periodValid_reg <= 1'b1;
		end
		else if (tick)
			ticksSince_reg <= ticksSince_reg + 8'h01;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	shadow_hold_a: assert property (pwmOn && !match2 |=> $stable(cmp1_reg) && $stable(cmp2_reg))
		else $error("compare value moved inside a pwm period");
	period_reload_a: assert property (pwmOn && match2 && !countWrite |=> count_reg == COUNT_RELOAD)
		else $error("period match did not reload the counter");
	pin_level_a: assert property (pwmOn && match1 && !match2 |=> lvl1_reg == $past(ctrl_reg.firstMatchLevel))
		else $error("first match level not applied");
	const_level_a: assert property (pwmOn && ctrl_reg.firstMatchLevel == ctrl_reg.secondMatchLevel
		|=> lvl1_reg == $past(ctrl_reg.firstMatchLevel))
		else $error("pin not held at the common level");
	tick_offset_a: assert property (pwmOn && match2 && periodValid_reg
		|-> 8'(ticksSince_reg + 8'h01) == 8'(cmp2_reg + PWM_TICK_OFFSET))
		else $error("period length is not compare value plus five");
	no_cmp_flag_a: assert property (pwmOn && !flag_reg[F_CMP1] && !flag_reg[F_CMP2]
		|=> !flag_reg[F_CMP1] && !flag_reg[F_CMP2])
		else $error("compare flag set in pwm mode");
	cap1_period_a: assert property (pwmOn && match2 |=> flag_reg[F_CAP1] ##1 irq_reg == ctrl_reg.captureIrqEnable
		|| $past(evtClr[F_CAP1]) == 1'b0)
		else $error("period match did not set capture one flag");
	unarmed_clear_a: assert property (flag_reg[F_OVF] && !armed_reg[F_OVF] && accessPh
		|=> flag_reg[F_OVF])
		else $error("overflow flag cleared without a status read");
	overflow_set_a: assert property (tick && count_reg == COUNT_TOP && !reload |=> flag_reg[F_OVF])
		else $error("rollover did not set overflow flag");
	freeze_hold_a: assert property (freeze_reg && !countWrite
		|=> $stable(count_reg) ##1 !pinOut.compareOutputDriven || !freeze_reg)
		else $error("frozen timer still running or driving");

endmodule // tpwm_timer

// ===== bench/tpwm_load.sv
`timescale 1ns/100ps
module tpwm_load
(
	input wire logic mclk,
	input wire logic reset,
	input wire tpwm_pkg::tpwm_pins_t pins,
	output logic echoPin,
	output logic [15:0] highLen,
	output logic [15:0] periodLen
);
	import tpwm_pkg::*;
	logic pinQ;
	logic [15:0] cycleCount;
	logic [15:0] riseAt;
	logic [1:0] echoCount;
	// ****************************************
	// pulse measurement on the output pin
	// ****************************************
	always @(posedge mclk)
	begin
		pinQ <= pins.compareOutputPin;
		cycleCount <= reset ? 16'h0000 : cycleCount + 16'h0001;
		if (pins.compareOutputPin && !pinQ)
		begin
			periodLen <= cycleCount - riseAt;
			riseAt <= cycleCount;
		end
		if (!pins.compareOutputPin && pinQ)
			highLen <= cycleCount - riseAt;
	end
	// ****************************************
	// acknowledge pulse back to the second capture pin
	// ****************************************
	// only a driven pin can be trusted, so a released pin never echoes
	always @(posedge mclk)
	begin
		if (reset)
			echoCount <= 2'h0;
		else if (!pins.compareOutputPin && pinQ && pins.compareOutputDriven)
			echoCount <= 2'h3;
		else if (echoCount != 2'h0)
			echoCount <= echoCount - 2'h1;
	end
	assign echoPin = (echoCount != 2'h0);
endmodule // tpwm_load

// ===== bench/tb.sv
`timescale 1ns/100ps
module tb;
	import tpwm_pkg::*;
	logic mclk, reset, psel, penable, pwrite, pslverr, pready;
	logic firstCapturePin, secondCapturePin, captureIrq, err;
	logic [7:0] paddr, held;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] highLen, periodLen;
	tpwm_pins_t pinOut;
	int failures, comparisons, bad;
	int cycles = 0;
	// rows: op (0 write, 1 read and compare, 2 read only), address, data
	localparam logic [19:0] ROWS [0:25] = '{
		20'h1_08_00, 20'h1_00_00, 20'h1_04_00, 20'h1_14_00, 20'h1_18_00,
		20'h1_1c_00, 20'h1_20_00, 20'h1_24_00, 20'h0_24_5a, 20'h1_24_00,
		20'h0_14_0a, 20'h0_18_14, 20'h0_00_81, 20'h1_14_0a, 20'h1_18_14,
		20'h1_00_81,
		20'h0_08_04, 20'h1_08_b4, 20'h2_10_00, 20'h1_08_b4, 20'h2_0c_00,
		20'h1_08_94, 20'h2_1c_00, 20'h1_08_14, 20'h2_20_00, 20'h1_08_04};

	tpwm_timer dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .firstCapturePin(firstCapturePin),
		.secondCapturePin(secondCapturePin), .pinOut(pinOut), .captureIrq(captureIrq));
	tpwm_load load_u (.mclk(mclk), .reset(reset), .pins(pinOut),
		.echoPin(secondCapturePin), .highLen(highLen), .periodLen(periodLen));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			complete_run();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task complete_run();
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// starts one edge on, so back-to-back calls never assign psel twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			failures++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task run_rows(input int lo, input int hi);
		for (int i = lo; i <= hi; i++)
		begin
			apb(ROWS[i][19:16] == 4'h0, ROWS[i][15:8], ROWS[i][7:0]);
			check(32'(err), 32'(ROWS[i][15:8] > 8'h20));
			if (ROWS[i][19:16] == 4'h1)
				check(rd, {24'h000000, ROWS[i][7:0]});
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		firstCapturePin = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		run_rows(0, 15);
		apb(1'b1, ADDR_CTRL2, 8'h98);
		repeat (600) @(posedge mclk);
		// flush compare flags left over from before pwm was on
		apb(1'b0, ADDR_STATUS, 8'h00);
		apb(1'b0, ADDR_CMP1, 8'h0a);
		apb(1'b0, ADDR_CMP2, 8'h14);
		for (int sel = 0; sel < 3; sel++)
		begin
			apb(1'b1, ADDR_CTRL2, 8'h98 | 8'(sel));
			repeat (600 << sel) @(posedge mclk);
			check(32'(periodLen), 32'(50 << sel));
			check(32'(highLen), 32'(20 << sel));
		end
		apb(1'b1, ADDR_CTRL2, 8'h98);
		apb(1'b1, ADDR_CMP1, 8'h08);
		repeat (300) @(posedge mclk);
		check(32'(highLen), 32'd24);
		check(32'(pinOut.compareOutputDriven), 32'd1);
		check(32'(captureIrq), 32'd1);
		run_rows(16, 25);
		check(32'(captureIrq), 32'd0);
		check(32'(pinOut.compareOutputDriven), 32'd0);
		check(32'(pinOut.secondCompareOutputDriven), 32'd0);
		check(32'(pinOut.secondCompareOutputPin), 32'd0);
		apb(1'b0, ADDR_COUNT, 8'h00);
		held = rd[7:0];
		repeat (40) @(posedge mclk);
		apb(1'b0, ADDR_COUNT, 8'h00);
		check(rd, {24'h000000, held});
		apb(1'b1, ADDR_CTRL2, 8'h00);
		// reserved status bits always written as zero
		apb(1'b1, ADDR_STATUS, 8'h00);
		repeat (1100) @(posedge mclk);
		apb(1'b0, ADDR_STATUS, 8'h00);
		check(rd, 32'h00000068);
		apb(1'b1, ADDR_CTRL1, 8'h03);
		apb(1'b1, ADDR_CTRL2, 8'h90);
		repeat (600) @(posedge mclk);
		bad = 0;
		repeat (100)
		begin
			@(posedge mclk);
			if (pinOut.compareOutputPin !== 1'b1)
				bad++;
		end
		check(32'(bad), 32'd0);
		firstCapturePin <= 1'b1;
		repeat (10) @(posedge mclk);
		apb(1'b1, ADDR_CAP1, 8'h00);
		check(rd, 32'h00000000);
		complete_run();
	end
endmodule // tb
